// >>> common/channel_alarm_params.svh
`ifndef CHANNEL_ALARM_PARAMS_SVH
`define CHANNEL_ALARM_PARAMS_SVH
// Channel counts
`define MEAS_CHANNELS 23
`define FLAG_CHANNELS 8
`define DIAL_NUMBERS 10
// Per channel configuration word map
`define CFG_WORDS 16
`define CFG_HYST 4
`define CFG_DELAY0 5
`define CFG_DELAY1 6
`define CFG_SLOTS 7
`define CFG_MISC 8
`define CFG_LAST 9
// Misc word fields
`define MISC_QUAL_BELOW 0
`define MISC_QUAL_ABOVE 2
`define MISC_SHUTDOWN 4
`define MISC_DIAL_WARN 5
`define MISC_DIAL_ALARM 6
`define MISC_SENSOR_CHK 7
`define MISC_SENSOR_SD 8
`define MISC_EVT_EN 9
`define MISC_EVT_SLOT 10
// Loop current window, units of 0.01 mA
`define LOOP_MIN 16'h0190
`define LOOP_MAX 16'h07D0
// Timebase
`define CLK_MHZ 200
`define TICK_MS 100
`define TICK_CYCLES (`TICK_MS * 1000 * `CLK_MHZ)
`define TICKS_PER_SEC 4'hA
`endif

// >>> common/channel_alarm_pkg.sv
package channel_alarm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EVAL = 2'b10
  } eval_state_e;
  typedef enum logic [1:0] {
    Q_ALWAYS = 2'b00,
    Q_HOLDOFF = 2'b01,
    Q_ON_START = 2'b10
  } qual_e;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_CALL = 2'b01,
    D_WAIT = 2'b10
  } dial_state_e;
endpackage

// >>> rtl/alarm_cfg_mem.sv
`timescale 1ns/100ps
module alarm_cfg_mem #(
  parameter int W = 16,
  parameter int AW = 9
) (
  // Clock
  input wire logic i_mclk,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// >>> rtl/alarm_timebase.sv
`timescale 1ns/100ps
`include "channel_alarm_params.svh"
module alarm_timebase #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Engine state
  input wire logic i_engine_running,
  input wire logic [15:0] i_holdoff_secs,
  // Time
  output logic [15:0] o_tenth_stamp,
  output logic o_holdoff_done
);
  logic [31:0] div_r;
  logic tick;
  logic [3:0] tenths_r;
  logic [15:0] secs_r;

  assign tick = (div_r == 32'(TICK_CYCLES - 1));

  // ****************
  // Tenth second tick
  // ****************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= 32'h0;
      o_tenth_stamp <= 16'h0;
    end else begin
      div_r <= tick ? 32'h0 : div_r + 32'h1;
      if (tick) begin
        o_tenth_stamp <= o_tenth_stamp + 16'h1;
      end
    end
  end

  // ****************
  // Hold-off timer
  // ****************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tenths_r <= 4'h0;
      secs_r <= 16'h0;
      o_holdoff_done <= 1'b0;
    end else if (!i_engine_running) begin
      tenths_r <= 4'h0;
      secs_r <= 16'h0;
      o_holdoff_done <= 1'b0;
    end else begin
      if (tick && !o_holdoff_done) begin
        if (tenths_r == `TICKS_PER_SEC - 4'h1) begin
          tenths_r <= 4'h0;
          secs_r <= secs_r + 16'h1;
        end else begin
          tenths_r <= tenths_r + 4'h1;
        end
      end
      o_holdoff_done <= (secs_r >= i_holdoff_secs);
    end
  end
endmodule

// >>> rtl/channel_alarm_evaluator.sv
`timescale 1ns/100ps
`include "channel_alarm_params.svh"
// Summary of operation
// - Independent alarm rules on all 23 channels
// - Any new alarm logs and sounds horn
// - Two alarms, two warnings, max two per type
// - Four thresholds per channel, display units
// - Two delays; condition must persist through it
// - Delay timers count tenths of seconds
// - Clear past threshold shifted by hysteresis, or on loss of qualifier
// - Alarm with shutdown selected requests shutdown
// - Dial-out selection for warnings, alarms, both
// - Dial ten numbers in priority order
// - Separate qualifier for below and above groups
// - Always-enabled qualifier evaluates at all times
// - Hold-off waits timer; engine stop cancels
// - On-start qualifier eligible once engine started
// - Loop current outside 4-20mA is sensor failure
// - Sensor failure shuts down or only alarms
// - Event log entry with stamp when condition
// - Hold-off interval programmed in seconds
// - Status flags evaluated as extra channels
module channel_alarm_evaluator #(
  parameter int NCH = `MEAS_CHANNELS + `FLAG_CHANNELS,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Measurement input
  input wire logic i_meas_valid,
  input wire logic [4:0] i_meas_chan,
  input wire logic signed [15:0] i_meas_value,
  input wire logic [15:0] i_meas_loop,
  output logic o_meas_ready,
  // Status flags
  input wire logic [`FLAG_CHANNELS-1:0] i_status_flags,
  // Configuration write
  input wire logic i_cfg_we,
  input wire logic [8:0] i_cfg_addr,
  input wire logic [15:0] i_cfg_data,
  // Engine state
  input wire logic i_engine_running,
  input wire logic [15:0] i_holdoff_secs,
  // Modem dialer
  input wire logic i_dial_done,
  input wire logic i_dial_fail,
  output logic o_dial_start,
  output logic [3:0] o_dial_index,
  // Alarm log and horn
  output logic o_log_valid,
  output logic [4:0] o_log_chan,
  output logic [4:0] o_log_code,
  output logic o_audible,
  output logic o_shutdown_req,
  // Event log
  output logic o_event_valid,
  output logic [4:0] o_event_chan,
  output logic [15:0] o_event_stamp,
  output logic [15:0] o_event_value
);
  channel_alarm_pkg::eval_state_e st_r;
  channel_alarm_pkg::dial_state_e dst_r;
  logic [4:0] chan_r;
  logic signed [15:0] val_r;
  logic [15:0] loop_r;
  logic [3:0] cnt_r;
  logic [15:0] cfg_r [`CFG_LAST];
  logic [63:0] stamp_r;
  logic [15:0] cfg_rdata;
  logic [63:0] stamp_rdata;
  logic [2:0] scan_r;
  logic [3:0] act_r [NCH];
  logic [3:0] pend_r [NCH];
  logic [NCH-1:0] sfail_r;
  logic [NCH-1:0] evt_r;
  logic [NCH-1:0] sd_r;
  logic [NCH-1:0] aud_r;
  logic dial_pend_r;
  logic [15:0] now;
  logic holdoff_done;
  logic take_meas;
  logic take_flag;
  logic [3:0] act_nxt;
  logic [3:0] pend_nxt;
  logic [63:0] stamp_nxt;
  logic sfail_nxt;
  logic evt_nxt;
  logic dial_req;

  // ****************
  // Helpers
  // ****************
  function automatic logic slot_ok(input logic [15:0] c, input int s);
    int n;
    n = 0;
    for (int k = 0; k < s; k++) begin
      if (c[4*k] && (c[4*k+1] == c[4*s+1])) begin
        n++;
      end
    end
    return c[4*s] && (n < 2);
  endfunction

  function automatic logic cmp(input logic above, input logic signed [16:0] v,
                               input logic signed [16:0] t);
    return above ? (v > t) : (v < t);
  endfunction

  // ****************
  // Submodules
  // ****************
  alarm_cfg_mem #(.W(16), .AW(9)) u_cfg (
    .i_mclk(i_mclk),
    .i_we(i_cfg_we),
    .i_waddr(i_cfg_addr),
    .i_wdata(i_cfg_data),
    .i_raddr({chan_r, cnt_r}),
    .o_rdata(cfg_rdata)
  );

  alarm_cfg_mem #(.W(64), .AW(5)) u_stamp (
    .i_mclk(i_mclk),
    .i_we(st_r == channel_alarm_pkg::ST_EVAL),
    .i_waddr(chan_r),
    .i_wdata(stamp_nxt),
    .i_raddr(chan_r),
    .o_rdata(stamp_rdata)
  );

  alarm_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_engine_running(i_engine_running),
    .i_holdoff_secs(i_holdoff_secs),
    .o_tenth_stamp(now),
    .o_holdoff_done(holdoff_done)
  );

  // ****************
  // Sequencer
  // ****************
  assign take_meas = (st_r == channel_alarm_pkg::ST_IDLE) && i_meas_valid;
  assign take_flag = (st_r == channel_alarm_pkg::ST_IDLE) && !i_meas_valid;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= channel_alarm_pkg::ST_IDLE;
      chan_r <= 5'h0;
      val_r <= 16'h0;
      loop_r <= 16'h0;
      cnt_r <= 4'h0;
      scan_r <= 3'h0;
      o_meas_ready <= 1'b1;
    end else begin
      case (st_r)
        channel_alarm_pkg::ST_IDLE: begin
          cnt_r <= 4'h0;
          st_r <= channel_alarm_pkg::ST_READ;
          o_meas_ready <= 1'b0;
          if (take_meas) begin
            chan_r <= i_meas_chan;
            val_r <= i_meas_value;
            loop_r <= i_meas_loop;
          end else if (take_flag) begin
            chan_r <= 5'(`MEAS_CHANNELS) + {2'h0, scan_r};
            val_r <= {15'h0, i_status_flags[scan_r]};
            loop_r <= `LOOP_MIN;
            scan_r <= scan_r + 3'h1;
          end
        end
        channel_alarm_pkg::ST_READ: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(`CFG_LAST)) begin
            st_r <= channel_alarm_pkg::ST_EVAL;
          end
        end
        channel_alarm_pkg::ST_EVAL: begin
          st_r <= channel_alarm_pkg::ST_IDLE;
          o_meas_ready <= 1'b1;
        end
        default: begin
          st_r <= channel_alarm_pkg::ST_IDLE;
          o_meas_ready <= 1'b1;
        end
      endcase
    end
  end

  // Capture of configuration words, one cycle behind the address
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stamp_r <= 64'h0;
      for (int i = 0; i < `CFG_LAST; i++) begin
        cfg_r[i] <= 16'h0;
      end
    end else if (st_r == channel_alarm_pkg::ST_READ && cnt_r != 4'h0) begin
      cfg_r[cnt_r - 4'h1] <= cfg_rdata;
      if (cnt_r == 4'h1) begin
        stamp_r <= stamp_rdata;
      end
    end
  end

  // ****************
  // Slot evaluation
  // ****************
  always_comb begin
    logic [1:0] q;
    logic above;
    logic en;
    logic elig;
    logic signed [16:0] v;
    logic signed [16:0] t;
    logic signed [16:0] h;
    logic [15:0] dly;
    logic [15:0] elapsed;
    logic [15:0] ctl;
    logic [15:0] misc;
    q = 2'h0;
    above = 1'b0;
    en = 1'b0;
    elig = 1'b0;
    t = 17'h0;
    dly = 16'h0;
    elapsed = 16'h0;
    ctl = cfg_r[`CFG_SLOTS];
    misc = cfg_r[`CFG_MISC];
    v = {val_r[15], val_r};
    h = {cfg_r[`CFG_HYST][15], cfg_r[`CFG_HYST]};
    act_nxt = act_r[chan_r];
    pend_nxt = pend_r[chan_r];
    stamp_nxt = stamp_r;
    for (int s = 0; s < 4; s++) begin
      above = ctl[4*s+1];
      en = slot_ok(ctl, s);
      q = above ? misc[`MISC_QUAL_ABOVE +: 2] : misc[`MISC_QUAL_BELOW +: 2];
      case (q)
        channel_alarm_pkg::Q_ALWAYS: elig = 1'b1;
        channel_alarm_pkg::Q_HOLDOFF: elig = holdoff_done;
        channel_alarm_pkg::Q_ON_START: elig = i_engine_running;
        default: elig = 1'b0;
      endcase
      t = {cfg_r[s][15], cfg_r[s]};
      case (ctl[4*s+2 +: 2])
        2'h1: dly = cfg_r[`CFG_DELAY0];
        2'h2: dly = cfg_r[`CFG_DELAY1];
        default: dly = 16'h0;
      endcase
      elapsed = now - stamp_r[16*s +: 16];
      if (!en || !elig) begin
        act_nxt[s] = 1'b0;
        pend_nxt[s] = 1'b0;
      end else if (act_r[chan_r][s]) begin
        act_nxt[s] = cmp(above, v, above ? t - h : t + h);
      end else if (cmp(above, v, t)) begin
        if (!pend_r[chan_r][s]) begin
          pend_nxt[s] = 1'b1;
          stamp_nxt[16*s +: 16] = now;
          act_nxt[s] = (dly == 16'h0);
        end else begin
          act_nxt[s] = (elapsed >= dly);
        end
      end else begin
        pend_nxt[s] = 1'b0;
      end
    end
    sfail_nxt = misc[`MISC_SENSOR_CHK] && (chan_r < 5'(`MEAS_CHANNELS)) &&
                ((loop_r < `LOOP_MIN) || (loop_r > `LOOP_MAX));
    t = {cfg_r[misc[`MISC_EVT_SLOT +: 2]][15], cfg_r[misc[`MISC_EVT_SLOT +: 2]]};
    evt_nxt = misc[`MISC_EVT_EN] &&
              cmp(ctl[4*misc[`MISC_EVT_SLOT +: 2]+1], v, t);
    dial_req = (misc[`MISC_DIAL_ALARM] && |(act_nxt[1:0] & ~act_r[chan_r][1:0])) ||
               (misc[`MISC_DIAL_WARN] && |(act_nxt[3:2] & ~act_r[chan_r][3:2]));
  end

  // ****************
  // Channel state
  // ****************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sfail_r <= '0;
      evt_r <= '0;
      sd_r <= '0;
      aud_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        act_r[c] <= 4'h0;
        pend_r[c] <= 4'h0;
      end
    end else if (st_r == channel_alarm_pkg::ST_EVAL) begin
      act_r[chan_r] <= act_nxt;
      pend_r[chan_r] <= pend_nxt;
      sfail_r[chan_r] <= sfail_nxt;
      evt_r[chan_r] <= evt_nxt;
      sd_r[chan_r] <= (cfg_r[`CFG_MISC][`MISC_SHUTDOWN] && |act_nxt[1:0]) ||
                      (cfg_r[`CFG_MISC][`MISC_SENSOR_SD] && sfail_nxt);
      aud_r[chan_r] <= |act_nxt || sfail_nxt;
    end
  end

  // ****************
  // Log, horn and shutdown outputs
  // ****************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_log_valid <= 1'b0;
      o_log_chan <= 5'h0;
      o_log_code <= 5'h0;
      o_event_valid <= 1'b0;
      o_event_chan <= 5'h0;
      o_event_stamp <= 16'h0;
      o_event_value <= 16'h0;
      o_audible <= 1'b0;
      o_shutdown_req <= 1'b0;
    end else begin
      o_audible <= |aud_r;
      o_shutdown_req <= |sd_r;
      o_log_valid <= 1'b0;
      o_event_valid <= 1'b0;
      if (st_r == channel_alarm_pkg::ST_EVAL) begin
        o_log_chan <= chan_r;
        o_log_code <= {sfail_nxt & ~sfail_r[chan_r], act_nxt & ~act_r[chan_r]};
        o_log_valid <= |(act_nxt & ~act_r[chan_r]) ||
                       (sfail_nxt && !sfail_r[chan_r]);
        o_event_valid <= evt_nxt && !evt_r[chan_r];
        o_event_chan <= chan_r;
        o_event_stamp <= now;
        o_event_value <= val_r;
      end
    end
  end

  // ****************
  // Dial-out sequencer
  // ****************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dst_r <= channel_alarm_pkg::D_IDLE;
      dial_pend_r <= 1'b0;
      o_dial_start <= 1'b0;
      o_dial_index <= 4'h0;
    end else begin
      o_dial_start <= 1'b0;
      dial_pend_r <= (st_r == channel_alarm_pkg::ST_EVAL && dial_req) ||
                     (dial_pend_r && dst_r != channel_alarm_pkg::D_IDLE);
      case (dst_r)
        channel_alarm_pkg::D_IDLE: begin
          if (dial_pend_r) begin
            o_dial_index <= 4'h0;
            dst_r <= channel_alarm_pkg::D_CALL;
          end
        end
        channel_alarm_pkg::D_CALL: begin
          o_dial_start <= 1'b1;
          dst_r <= channel_alarm_pkg::D_WAIT;
        end
        channel_alarm_pkg::D_WAIT: begin
          if (i_dial_done) begin
            dst_r <= channel_alarm_pkg::D_IDLE;
          end else if (i_dial_fail) begin
            if (o_dial_index == 4'(`DIAL_NUMBERS - 1)) begin
              dst_r <= channel_alarm_pkg::D_IDLE;
            end else begin
              o_dial_index <= o_dial_index + 4'h1;
              dst_r <= channel_alarm_pkg::D_CALL;
            end
          end
        end
        default: dst_r <= channel_alarm_pkg::D_IDLE;
      endcase
    end
  end
endmodule

// >>> verif/channel_alarm_evaluator_sva.sv
`timescale 1ns/100ps
// ****
// Port checker
// ****
module channel_alarm_checker (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_dial_fail,
  input wire logic o_meas_ready,
  input wire logic o_dial_start,
  input wire logic [3:0] o_dial_index,
  input wire logic o_log_valid,
  input wire logic o_audible,
  input wire logic o_event_valid
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  chk_busy_hold: assert property ($fell(o_meas_ready) |-> !o_meas_ready [*8])
    else $error("ready returned early");
  chk_ready_back: assert property ($fell(o_meas_ready) |-> ##11 o_meas_ready)
    else $error("ready not back twelve cycles after the take");
  chk_log_sync: assert property (o_log_valid |-> $rose(o_meas_ready))
    else $error("log pulse off the result edge");
  chk_log_pulse: assert property (o_log_valid |=> !o_log_valid)
    else $error("log pulse too long");
  chk_horn_on: assert property (o_log_valid |-> ##[1:2] o_audible)
    else $error("horn silent after new alarm");
  chk_event_sync: assert property (o_event_valid |-> $rose(o_meas_ready))
    else $error("event pulse off the result edge");
  chk_dial_pulse: assert property (o_dial_start |=> !o_dial_start)
    else $error("dial start too long");
  chk_dial_next: assert property (i_dial_fail && o_dial_index != 4'h9 |-> ##[1:3] o_dial_start)
    else $error("next number not tried");
  chk_idx_range: assert property (o_dial_start |-> o_dial_index <= 4'h9)
    else $error("dial index out of list");
endmodule
bind channel_alarm_evaluator channel_alarm_checker chk_u (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_dial_fail(i_dial_fail), .o_meas_ready(o_meas_ready),
  .o_dial_start(o_dial_start), .o_dial_index(o_dial_index), .o_log_valid(o_log_valid),
  .o_audible(o_audible), .o_event_valid(o_event_valid));

// >>> verif/meas_chain_model.sv
`timescale 1ns/100ps
// ****
// Measurement chain and modem
// ****
module meas_chain_model (
  // Clock
  input wire logic i_mclk,
  // Handshakes from evaluator
  input wire logic i_meas_ready,
  input wire logic i_dial_start,
  // Measurement offer
  output logic o_meas_valid,
  output logic [4:0] o_meas_chan,
  output logic signed [15:0] o_meas_value,
  output logic [15:0] o_meas_loop,
  // Modem result
  output logic o_dial_done,
  output logic o_dial_fail
);
  logic [2:0] wait_r = 3'h0;
  initial begin
    o_meas_valid = 1'b0;
    o_meas_chan = 5'h00;
    o_meas_value = 16'h0000;
    o_meas_loop = 16'h0000;
    o_dial_done = 1'b0;
    o_dial_fail = 1'b0;
  end
  // Every call fails after a short wait
  always @(negedge i_mclk) begin
    o_dial_fail <= (wait_r == 3'h1);
    if (i_dial_start)
      wait_r <= 3'h3;
    else if (wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
  end
  // Offer held until taken, then lines scrambled
  task automatic send(input logic [4:0] ch, input logic [15:0] v, input logic [15:0] lp);
    @(negedge i_mclk);
    o_meas_valid = 1'b1;
    o_meas_chan = ch;
    o_meas_value = v;
    o_meas_loop = lp;
    while (i_meas_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    o_meas_valid = 1'b0;
    o_meas_value = ~v;
    o_meas_loop = ~lp;
  endtask
endmodule

// >>> verif/channel_alarm_evaluator_bench.sv
`timescale 1ns/100ps
`define CHK(n, a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
// ****
// Bench
// ****
module channel_alarm_evaluator_bench;
  localparam logic [15:0] lp_ok = 16'h03E8;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, i_cfg_we = 1'b0, i_engine_running = 1'b0;
  logic [8:0] i_cfg_addr = 9'h000;
  logic [15:0] i_cfg_data = 16'h0000, i_holdoff_secs = 16'h0001;
  logic [7:0] i_status_flags = 8'h00;
  logic i_meas_valid, i_dial_done, i_dial_fail, o_meas_ready, o_dial_start, o_log_valid;
  logic o_audible, o_shutdown_req, o_event_valid, ev_seen;
  logic [4:0] i_meas_chan, o_log_chan, o_log_code, o_event_chan, exp_idx = 5'h00;
  logic signed [15:0] i_meas_value;
  logic [15:0] i_meas_loop, o_event_stamp, o_event_value, ev_val;
  logic [3:0] o_dial_index;
  int fail_count = 0, comparisons = 0;
  initial forever #2.5 i_mclk = ~i_mclk;
  channel_alarm_evaluator #(.TICK_CYCLES(10)) dut_u (.i_mclk, .i_arst_n, .i_meas_valid,
    .i_meas_chan, .i_meas_value, .i_meas_loop, .o_meas_ready, .i_status_flags, .i_cfg_we,
    .i_cfg_addr, .i_cfg_data, .i_engine_running, .i_holdoff_secs, .i_dial_done, .i_dial_fail,
    .o_dial_start, .o_dial_index, .o_log_valid, .o_log_chan, .o_log_code, .o_audible,
    .o_shutdown_req, .o_event_valid, .o_event_chan, .o_event_stamp, .o_event_value);
  meas_chain_model src_u (.i_mclk(i_mclk), .i_meas_ready(o_meas_ready),
    .i_dial_start(o_dial_start), .o_meas_valid(i_meas_valid), .o_meas_chan(i_meas_chan),
    .o_meas_value(i_meas_value), .o_meas_loop(i_meas_loop), .o_dial_done(i_dial_done),
    .o_dial_fail(i_dial_fail));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge i_mclk);
    i_arst_n = 1'b0;
    repeat (8) @(negedge i_mclk);
    i_arst_n = 1'b1;
  endtask
  task automatic cfg(input int ch, input int w, input logic [15:0] d);
    @(negedge i_mclk);
    i_cfg_we = 1'b1;
    i_cfg_addr = {ch[4:0], w[3:0]};
    i_cfg_data = d;
    @(negedge i_mclk);
    i_cfg_we = 1'b0;
  endtask
  task automatic meas(input logic [4:0] ch, input logic [15:0] v, input logic [15:0] lp,
                      input logic [4:0] code);
    int n;
    src_u.send(ch, v, lp);
    n = 0;
    while (o_meas_ready !== 1'b1 && n < 30) begin
      @(negedge i_mclk);
      n++;
    end
    `CHK("log_code", o_log_valid ? o_log_code : 5'h00, code)
    `CHK("log_chan", o_log_chan, ch)
    `CHK("event_chan", o_event_chan, ch)
    ev_seen = o_event_valid;
    ev_val = o_event_value;
    repeat (2) @(negedge i_mclk);
  endtask
  always @(negedge i_mclk) begin
    if (o_dial_start === 1'b1) begin
      `CHK("dial_index", o_dial_index, exp_idx[3:0])
      exp_idx++;
    end
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    print_verdict();
  end
  initial begin
    do_reset();
    for (int c = 0; c < 31; c++)
      for (int w = 0; w < 10; w++)
        cfg(c, w, 16'h0000);
    cfg(0, 0, 16'h0064);
    cfg(0, 4, 16'h000A);
    cfg(0, 7, 16'h0003);
    cfg(0, 8, 16'h0240);
    cfg(1, 0, 16'h0032);
    cfg(1, 2, 16'h00C8);
    cfg(1, 7, 16'h0301);
    cfg(1, 8, 16'h0012);
    cfg(2, 8, 16'h0180);
    cfg(3, 5, 16'h0004);
    cfg(3, 7, 16'h0007);
    cfg(4, 7, 16'h0003);
    cfg(4, 8, 16'h0004);
    cfg(23, 7, 16'h0003);
    do_reset();
    i_status_flags = 8'h01;
    repeat (150) @(negedge i_mclk);
    `CHK("flag_horn", o_audible, 1'b1)
    i_status_flags = 8'h00;
    repeat (150) @(negedge i_mclk);
    `CHK("flag_quiet", o_audible, 1'b0)
    meas(5'h00, 16'h0064, lp_ok, 5'h00);
    meas(5'h00, 16'h0065, lp_ok, 5'h01);
    `CHK("event", {ev_seen, ev_val}, {1'b1, 16'h0065})
    `CHK("horn_on", o_audible, 1'b1)
    meas(5'h00, 16'h005B, lp_ok, 5'h00);
    `CHK("horn_held", o_audible, 1'b1)
    meas(5'h00, 16'h005A, lp_ok, 5'h00);
    `CHK("horn_off", {o_audible, o_shutdown_req}, 2'h0)
    meas(5'h03, 16'h0005, lp_ok, 5'h00);
    meas(5'h03, 16'h0005, lp_ok, 5'h00);
    repeat (60) @(negedge i_mclk);
    meas(5'h03, 16'h0005, lp_ok, 5'h01);
    meas(5'h02, 16'h0000, 16'h0190, 5'h00);
    meas(5'h02, 16'h0000, 16'h012C, 5'h10);
    `CHK("sensor_stop", o_shutdown_req, 1'b1)
    `CHK("dial_calls", exp_idx, 5'h0A)
    do_reset();
    meas(5'h01, 16'h0028, lp_ok, 5'h00);
    meas(5'h01, 16'h00FA, lp_ok, 5'h04);
    `CHK("warn_no_stop", o_shutdown_req, 1'b0)
    i_engine_running = 1'b1;
    meas(5'h01, 16'h0028, lp_ok, 5'h01);
    `CHK("alarm_stop", o_shutdown_req, 1'b1)
    meas(5'h04, 16'h0005, lp_ok, 5'h00);
    repeat (120) @(negedge i_mclk);
    meas(5'h04, 16'h0005, lp_ok, 5'h01);
    i_engine_running = 1'b0;
    meas(5'h04, 16'h0005, lp_ok, 5'h00);
    i_engine_running = 1'b1;
    meas(5'h04, 16'h0005, lp_ok, 5'h00);
    print_verdict();
  end
endmodule
